// ===== bench/pfi_irq_ctrl_checker.sv
`default_nettype none

module pfi_irq_ctrl_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    input wire logic mode_switch_event,
    input wire logic fault_first_flag,
    input wire logic fault_second_flag,
    input wire logic fault_combined_flag,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 100ps;

    // ==========================================================
    // Shadows of the enable, clear and mask fields, kept from bus traffic only
    // ==========================================================
    logic [3:0] en;
    logic [3:0] msk;
    logic clr;
    wire logic rd_ctl = rd && addr == pfi_pkg::ADDR_CONTROL;
    wire logic wr_ctl = wr && addr == pfi_pkg::ADDR_CONTROL;
    wire logic wr_msk = wr && addr == pfi_pkg::ADDR_MASK;
    wire logic [2:0] flt = {fault_first_flag, fault_second_flag, fault_combined_flag};

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            en <= 4'h0;
            clr <= 1'b0;
            msk <= 4'hF;
        end
        else
        begin
            if (wr_ctl)
            begin
                en <= wdata[9:6];
                clr <= wdata[11];
            end
            if (wr_msk)
                msk <= wdata[9:6];
        end
    end

    // ==========================================================
    // Properties
    // ==========================================================
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    AST_EN_MODE: assert property (rd_ctl |=> rdata[9] == en[3])
        else $error("mode enable readback wrong");
    AST_EN_FIRST: assert property (rd_ctl |=> rdata[8] == en[2])
        else $error("first fault enable readback wrong");
    AST_EN_SECOND: assert property (rd_ctl |=> rdata[7] == en[1])
        else $error("second fault enable readback wrong");
    AST_EN_COMB: assert property (rd_ctl |=> rdata[6] == en[0])
        else $error("combined fault enable readback wrong");
    AST_INT_BIT: assert property (rd_ctl |=> rdata[16] == $past(irq))
        else $error("interrupt status bit differs from irq");
    AST_FAULT_IRQ: assert property (|(flt & en[2:0] & msk[2:0]) && !wr_msk |=> irq)
        else $error("enabled fault did not raise irq");
    AST_MASK_OFF: assert property (msk == 4'h0 |-> !irq)
        else $error("irq high with all sources masked");
    AST_MODE_CLR: assert property (wr_ctl && wdata[11] && !clr && !mode_switch_event ##1 rd_ctl
        |=> !rdata[22])
        else $error("mode flag survived clear edge");

    cover property ($rose(irq));
    cover property (rd_ctl ##1 rdata[22]);
    cover property (wr_ctl && wdata[11] && !clr);
endmodule

bind pfi_irq_ctrl pfi_irq_ctrl_checker u_chk (
    .clk(clk),
    .rst_n(rst_n),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .rd(rd),
    .rdata(rdata),
    .mode_switch_event(mode_switch_event),
    .fault_first_flag(fault_first_flag),
    .fault_second_flag(fault_second_flag),
    .fault_combined_flag(fault_combined_flag),
    .irq(irq)
);

`default_nettype wire

// ===== bench/pfi_irq_ctrl_test.sv
`default_nettype none

module pfi_irq_ctrl_test;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic ev = 1'b0;
    logic [2:0] flt = 3'h0;
    logic [31:0] rdata;
    logic irq;
    int err_total = 0;
    int tests_run = 0;
    int cyc = 0;

    pfi_irq_ctrl dut (
        .clk(clk),
        .rst_n(rst_n),
        .addr(addr),
        .wdata(wdata),
        .wr(wr),
        .rd(rd),
        .rdata(rdata),
        .mode_switch_event(ev),
        .fault_first_flag(flt[2]),
        .fault_second_flag(flt[1]),
        .fault_combined_flag(flt[0]),
        .irq(irq)
    );

    initial
    begin
        forever #12.5 clk = ~clk;
    end

    // ==========================================================
    // Bus and compare helpers
    // ==========================================================
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata & m, e);
    endtask

    // Write then read the same address with no idle cycle between the strobes
    task automatic wr_rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
        input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata & m, e);
    endtask

    task automatic irq_chk(input logic e);
        #1;
        chk({31'h0, irq}, {31'h0, e});
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic pulse_ev;
        @(posedge clk);
        ev <= 1'b1;
        @(posedge clk);
        ev <= 1'b0;
    endtask

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_reset;
        rd_chk(pfi_pkg::ADDR_CONTROL, 32'hFFFF_FFFF, 32'h0);
        rd_chk(pfi_pkg::ADDR_MASK, 32'h0000_03C0, 32'h0000_03C0);
        rd_chk(8'h0C, 32'hFFFF_FFFF, 32'h0);
        irq_chk(1'b0);
        $display("test reset done");
    endtask

    task automatic t_enables;
        for (int i = 6; i < 10; i++)
        begin
            wr_reg(pfi_pkg::ADDR_CONTROL, 32'h1 << i);
            rd_chk(pfi_pkg::ADDR_CONTROL, 32'h3C0, 32'h1 << i);
        end
        $display("test enables done");
    endtask

    // Each fault is first held with its enable off, then enabled
    task automatic t_faults;
        for (int i = 0; i < 3; i++)
        begin
            wr_reg(pfi_pkg::ADDR_CONTROL, 32'h0);
            @(posedge clk);
            flt <= 3'b001 << i;
            wait_cyc(3);
            irq_chk(1'b0);
            rd_chk(pfi_pkg::ADDR_CONTROL, 32'h0001_0000, 32'h0);
            wr_reg(pfi_pkg::ADDR_CONTROL, 32'h40 << i);
            wait_cyc(2);
            irq_chk(1'b1);
            rd_chk(pfi_pkg::ADDR_CONTROL, 32'h0001_0000, 32'h0001_0000);
            @(posedge clk);
            flt <= 3'b000;
            wr_reg(pfi_pkg::ADDR_STATUS, 32'h3C0);
            wait_cyc(1);
            irq_chk(1'b0);
        end
        $display("test faults done");
    endtask

    task automatic t_mask;
        wr_reg(pfi_pkg::ADDR_CONTROL, 32'h100);
        wr_reg(pfi_pkg::ADDR_MASK, 32'h0);
        @(posedge clk);
        flt <= 3'b100;
        wait_cyc(3);
        irq_chk(1'b0);
        rd_chk(pfi_pkg::ADDR_STATUS, 32'h3C0, 32'h100);
        wr_reg(pfi_pkg::ADDR_MASK, 32'h3C0);
        irq_chk(1'b1);
        @(posedge clk);
        flt <= 3'b000;
        wr_reg(pfi_pkg::ADDR_STATUS, 32'h3C0);
        irq_chk(1'b0);
        $display("test mask done");
    endtask

    // Clear acts only on a 0 to 1 change of the stored clear bit
    task automatic t_mode;
        // Flag generation off: an event must leave the flag and irq low
        wr_reg(pfi_pkg::ADDR_CONTROL, 32'h200);
        pulse_ev;
        rd_chk(pfi_pkg::ADDR_CONTROL, 32'h0041_0000, 32'h0);
        wr_reg(pfi_pkg::ADDR_CONTROL, 32'h600);
        pulse_ev;
        wait_cyc(2);
        irq_chk(1'b1);
        rd_chk(pfi_pkg::ADDR_CONTROL, 32'h0041_0000, 32'h0041_0000);
        wr_rd(pfi_pkg::ADDR_CONTROL, 32'hE00, 32'h0040_0800, 32'h800);
        pulse_ev;
        wr_reg(pfi_pkg::ADDR_CONTROL, 32'hE00);
        rd_chk(pfi_pkg::ADDR_CONTROL, 32'h0040_0000, 32'h0040_0000);
        wr_reg(pfi_pkg::ADDR_CONTROL, 32'h600);
        wr_rd(pfi_pkg::ADDR_CONTROL, 32'hE00, 32'h0040_0000, 32'h0);
        wr_reg(pfi_pkg::ADDR_STATUS, 32'h200);
        irq_chk(1'b0);
        $display("test mode done");
    endtask

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            err_total++;
            give_verdict;
        end
    end

    initial
    begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_reset;
        t_enables;
        t_faults;
        t_mask;
        t_mode;
        give_verdict;
    end
endmodule

`default_nettype wire

// ===== include/pfi_irq_if.sv
`default_nettype none

interface pfi_irq_if;
    logic [3:0] src;
    logic status_clr;
    logic mask_wr;
    logic [3:0] wdata;
    logic [3:0] status;
    logic [3:0] mask;
    logic irq;

    modport ctrl (
        output src,
        output status_clr,
        output mask_wr,
        output wdata,
        input status,
        input mask,
        input irq
    );

    modport core (
        input src,
        input status_clr,
        input mask_wr,
        input wdata,
        output status,
        output mask,
        output irq
    );
endinterface

`default_nettype wire

// ===== include/pfi_pkg.sv
`default_nettype none

package pfi_pkg;

    // ==========================================================
    // Register bus
    // ==========================================================
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_MASK = 8'h08;

    // ==========================================================
    // Interrupt control register fields
    // ==========================================================
    localparam int BIT_MODE_FLAG = 22;
    localparam int BIT_FAULT_FIRST_FLAG = 21;
    localparam int BIT_FAULT_SECOND_FLAG = 20;
    localparam int BIT_FAULT_COMBINED_FLAG = 19;
    localparam int BIT_INT_OUT = 16;
    localparam int BIT_AUTO_SWITCH_FLAG_CLEAR = 11;
    localparam int BIT_MODE_FLAG_GEN_EN = 10;
    localparam int BIT_MODE_IRQ_EN = 9;
    localparam int BIT_FAULT_FIRST_IRQ_EN = 8;
    localparam int BIT_FAULT_SECOND_IRQ_EN = 7;
    localparam int BIT_FAULT_COMBINED_IRQ_EN = 6;

    // Four sources, index 3 = mode switch down to 0 = fault combined
    localparam int NSRC = 4;
    localparam int SRC_LSB = 6;
    localparam int FLAG_LSB = 19;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [3:0] RST_ENABLES = 4'h0;
    localparam logic RST_FLAG_GEN_EN = 1'b0;
    localparam logic RST_FLAG_CLEAR = 1'b0;
    localparam logic RST_MODE_FLAG = 1'b0;
    localparam logic [3:0] RST_STATUS = 4'h0;
    localparam logic [3:0] RST_MASK = 4'hF;
    localparam logic [31:0] RST_READ = 32'h0000_0000;

endpackage

`default_nettype wire

// ===== verilog/pfi_irq_core.sv
`default_nettype none

module pfi_irq_core (
    input wire logic clk,
    input wire logic rst_n,
    pfi_irq_if.core bus
);

    logic [3:0] status;
    logic [3:0] mask;

    // ==========================================================
    // Sticky status: a source held high sets its bit every cycle,
    // so a write-one-to-clear never wins over a live source
    // ==========================================================
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            status <= pfi_pkg::RST_STATUS;
        end
        else
        begin
            status <= (status & ~({4{bus.status_clr}} & bus.wdata)) | bus.src;
        end
    end

    // ==========================================================
    // Mask
    // ==========================================================
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mask <= pfi_pkg::RST_MASK;
        end
        else if (bus.mask_wr)
        begin
            mask <= bus.wdata;
        end
    end

    assign bus.status = status;
    assign bus.mask = mask;
    assign bus.irq = |(status & mask); // [RQ7]

endmodule

`default_nettype wire

// ===== verilog/pfi_irq_ctrl.sv
// Behaviour
// (RQ1) Bit 9 enables mode-switch flag interrupt, reset 0
// (RQ2) Bit 8 enables fault first interrupt, reset 0
// (RQ3) Bit 7 enables fault second interrupt, reset 0
// (RQ4) Bit 6 enables fault combined interrupt, reset 0
// (RQ5) Bit 16 reads interrupt output level
// (RQ6) Rising write on bit 11 clears mode flag; here an event in the same cycle with bit 10 set keeps the flag set
// (RQ7) Interrupt when any enabled flag is set; here only while its mask bit is also set
`default_nettype none

module pfi_irq_ctrl (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic mode_switch_event,
    input wire logic fault_first_flag,
    input wire logic fault_second_flag,
    input wire logic fault_combined_flag,
    output logic irq
);

    // ==========================================================
    // Address decode
    // ==========================================================
    function automatic logic hit(
        input logic [7:0] a,
        input logic [7:0] reg_addr
    );
        hit = (a == reg_addr);
    endfunction

    logic wr_control;
    logic wr_status;
    logic wr_mask;
    logic rd_mapped;

    assign wr_control = wr && hit(addr, pfi_pkg::ADDR_CONTROL);
    assign wr_status = wr && hit(addr, pfi_pkg::ADDR_STATUS);
    assign wr_mask = wr && hit(addr, pfi_pkg::ADDR_MASK);
    assign rd_mapped = hit(addr, pfi_pkg::ADDR_CONTROL)
        || hit(addr, pfi_pkg::ADDR_STATUS)
        || hit(addr, pfi_pkg::ADDR_MASK);

    // ==========================================================
    // Interrupt enables, bits 9 to 6
    // ==========================================================
    logic [3:0] irq_enable;
    logic mode_irq_enable;
    logic fault_first_irq_enable;
    logic fault_second_irq_enable;
    logic fault_combined_irq_enable;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_enable <= pfi_pkg::RST_ENABLES; // [RQ1] [RQ2] [RQ3] [RQ4]
        end
        else if (wr_control)
        begin
            irq_enable <= wdata[pfi_pkg::SRC_LSB +: pfi_pkg::NSRC]; // [RQ1] [RQ2] [RQ3] [RQ4]
        end
    end

    assign mode_irq_enable = irq_enable[pfi_pkg::BIT_MODE_IRQ_EN - pfi_pkg::SRC_LSB];
    assign fault_first_irq_enable =
        irq_enable[pfi_pkg::BIT_FAULT_FIRST_IRQ_EN - pfi_pkg::SRC_LSB];
    assign fault_second_irq_enable =
        irq_enable[pfi_pkg::BIT_FAULT_SECOND_IRQ_EN - pfi_pkg::SRC_LSB];
    assign fault_combined_irq_enable =
        irq_enable[pfi_pkg::BIT_FAULT_COMBINED_IRQ_EN - pfi_pkg::SRC_LSB];

    // ==========================================================
    // Mode-switch flag generation enable, bit 10
    // ==========================================================
    logic mode_flag_gen_en;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_flag_gen_en <= pfi_pkg::RST_FLAG_GEN_EN;
        end
        else if (wr_control)
        begin
            mode_flag_gen_en <= wdata[pfi_pkg::BIT_MODE_FLAG_GEN_EN];
        end
    end

    // ==========================================================
    // Flag clear control, bit 11
    // ==========================================================
    // Only a 0 to 1 change of the stored bit clears; writing 1 over 1
    // does nothing, so software must write 0 first.
    logic auto_switch_flag_clear;
    logic next_auto_switch_flag_clear;
    logic clear_edge;

    assign next_auto_switch_flag_clear = wdata[pfi_pkg::BIT_AUTO_SWITCH_FLAG_CLEAR];
    assign clear_edge = wr_control && next_auto_switch_flag_clear
        && !auto_switch_flag_clear; // [RQ6]

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            auto_switch_flag_clear <= pfi_pkg::RST_FLAG_CLEAR;
        end
        else if (wr_control)
        begin
            auto_switch_flag_clear <= next_auto_switch_flag_clear;
        end
    end

    // ==========================================================
    // Mode-switch flag
    // ==========================================================
    // A new event in the clearing cycle wins while bit 10 is set, so it is not lost then.
    logic mode_switch_flag;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_switch_flag <= pfi_pkg::RST_MODE_FLAG;
        end
        else if (mode_switch_event && mode_flag_gen_en)
        begin
            mode_switch_flag <= 1'b1;
        end
        else if (clear_edge)
        begin
            mode_switch_flag <= 1'b0; // [RQ6]
        end
    end

    // ==========================================================
    // Source gating and interrupt core
    // ==========================================================
    logic [3:0] flags;
    pfi_irq_if irq_bus ();

    assign flags = {mode_switch_flag, fault_first_flag, fault_second_flag,
        fault_combined_flag};

    genvar g;
    generate
        for (g = 0; g < pfi_pkg::NSRC; g++)
        begin : gen_src
            assign irq_bus.src[g] = flags[g] && irq_enable[g]; // [RQ7]
        end
    endgenerate

    assign irq_bus.status_clr = wr_status;
    assign irq_bus.mask_wr = wr_mask;
    assign irq_bus.wdata = wdata[pfi_pkg::SRC_LSB +: pfi_pkg::NSRC];

    pfi_irq_core u_core (
        .clk(clk),
        .rst_n(rst_n),
        .bus(irq_bus.core)
    );

    assign irq = irq_bus.irq; // [RQ7]

    // ==========================================================
    // Read data
    // ==========================================================
    // Reserved and unimplemented fields read as zero.
    logic [31:0] control_view;
    logic [31:0] status_view;
    logic [31:0] mask_view;
    logic [31:0] next_rdata;

    always_comb
    begin
        control_view = '0;
        control_view[pfi_pkg::BIT_MODE_FLAG] = mode_switch_flag;
        control_view[pfi_pkg::BIT_FAULT_FIRST_FLAG] = fault_first_flag;
        control_view[pfi_pkg::BIT_FAULT_SECOND_FLAG] = fault_second_flag;
        control_view[pfi_pkg::BIT_FAULT_COMBINED_FLAG] = fault_combined_flag;
        control_view[pfi_pkg::BIT_INT_OUT] = irq_bus.irq; // [RQ5]
        control_view[pfi_pkg::BIT_AUTO_SWITCH_FLAG_CLEAR] = auto_switch_flag_clear;
        control_view[pfi_pkg::BIT_MODE_FLAG_GEN_EN] = mode_flag_gen_en;
        control_view[pfi_pkg::BIT_MODE_IRQ_EN] = mode_irq_enable; // [RQ1]
        control_view[pfi_pkg::BIT_FAULT_FIRST_IRQ_EN] = fault_first_irq_enable; // [RQ2]
        control_view[pfi_pkg::BIT_FAULT_SECOND_IRQ_EN] = fault_second_irq_enable; // [RQ3]
        control_view[pfi_pkg::BIT_FAULT_COMBINED_IRQ_EN] = fault_combined_irq_enable; // [RQ4]
    end

    always_comb
    begin
        status_view = '0;
        mask_view = '0;
        status_view[pfi_pkg::SRC_LSB +: pfi_pkg::NSRC] = irq_bus.status;
        mask_view[pfi_pkg::SRC_LSB +: pfi_pkg::NSRC] = irq_bus.mask;
    end

    always_comb
    begin
        next_rdata = '0;
        if (rd && rd_mapped)
        begin
            if (hit(addr, pfi_pkg::ADDR_CONTROL))
            begin
                next_rdata = control_view;
            end
            else if (hit(addr, pfi_pkg::ADDR_STATUS))
            begin
                next_rdata = status_view;
            end
            else
            begin
                next_rdata = mask_view;
            end
        end
    end

    // Data stand only in the cycle after the read strobe.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata <= pfi_pkg::RST_READ;
        end
        else
        begin
            rdata <= next_rdata;
        end
    end

endmodule

`default_nettype wire
